// File: common/safety_blocks_defines.svh
// Functional notes
// - Enable mode starts when the enabling switch turns to Run.
// - In enable mode only enabling switch and stop input decide the output.
// - Block reset restores normal run: safeguard and stop input decide again.
// - Enable mode ends only with switch off and block reset together.
// - Enable time limit 1 s default up to 30 min, never disabled.
// - Enable timer expiry turns the controlled safety output off.
// - New enable cycle with reloaded timer needs switch on, off, on again.
// - Output on-delay and off-delay still apply during enable mode.
// - Stop input always turns the output off; enabling switch cannot override.
// - Latch reset accepted only with inputs in Run and permit high.
// - Latch output drops and stays latched off when an input goes to Stop.
// - Manual reset selectable as monitored or non-monitored.
// - Reference signal of a safety output is high while that output is on.
// - Safeguard stop during valid mute latches; reset needed to stay on after mute.
// - Without that reset, the downstream output drops when the mute ends.
// - Five mute types: one or two way, one or two sensor pairs.
// - With bypass option, choose normal bypass or mute-dependent override.
// - Override restarts a mute only with a sensor active and safeguard in Stop.
// - Normal bypass ignores the safeguard and keeps the mute output on.
// - Everything ANDed into the protected input is suppressed during mute.
// - Both sensors of a pair must activate within 3 s of each other.
// - Mute takes effect 100 ms after the second sensor is satisfied.
`ifndef SAFETY_BLOCKS_DEFINES_SVH
`define SAFETY_BLOCKS_DEFINES_SVH

// ----------------------------------------
// Clock and scan timing
// ----------------------------------------
`define CLK_PERIOD_NS     5
`define SCAN_PERIOD_US    1000
`define SCAN_CYCLES       ((`SCAN_PERIOD_US * 1000) / `CLK_PERIOD_NS)
`define MS_PER_SCAN       (`SCAN_PERIOD_US / 1000)

// ----------------------------------------
// Timer limits in milliseconds
// ----------------------------------------
`define ED_LIMIT_MIN_MS   21'd1000
`define ED_LIMIT_MAX_MS   21'd1800000
`define ED_LIMIT_RST_MS   21'd1000
`define MUTE_SIMUL_MS     12'd3000
`define MUTE_SETTLE_MS    12'd100

// ----------------------------------------
// Input vector bit positions
// ----------------------------------------
`define PIN_ENABLE_SW     0
`define PIN_STOP          1
`define PIN_ED_RESET      2
`define PIN_MAN_RESET     3
`define PIN_PERMIT        4
`define PIN_P1A           5
`define PIN_P1B           6
`define PIN_P2A           7
`define PIN_P2B           8
`define PIN_MUTE_PERMIT   9
`define PIN_BYPASS        10
`define PIN_GUARD         11
`define PIN_ESTOP         12
`define PIN_COUNT         13

`endif

// File: common/safety_blocks_pkg.sv
package safety_blocks_pkg;

    // Mute function types
    typedef enum logic [2:0] {
        MT_ONE_WAY_1P   = 3'h0,
        MT_TWO_WAY_1P   = 3'h1,
        MT_ONE_WAY_2P   = 3'h2,
        MT_TWO_WAY_2P   = 3'h3,
        MT_TWO_WAY_1P_X = 3'h4
    } mute_type_t;

    // Static configuration, same clock domain
    typedef struct packed {
        logic [20:0] ed_limit_ms;
        logic [15:0] on_delay_ms;
        logic [15:0] off_delay_ms;
        logic        reset_monitored;
        logic        permit_from_ref;
        mute_type_t  mute_type;
        logic        bypass_en;
        logic        bypass_override;
        logic        estop_before_mute;
    } safety_cfg_t;

    typedef enum logic [1:0] {
        ED_RUN     = 2'h0,
        ED_ENABLE  = 2'h1,
        ED_EXPIRED = 2'h2
    } ed_state_t;

    typedef enum logic [2:0] {
        MU_IDLE   = 3'h0,
        MU_WAIT2  = 3'h1,
        MU_SETTLE = 3'h2,
        MU_MUTED  = 3'h3,
        MU_BLOCK  = 3'h4
    } mute_state_t;

endpackage

// File: logic/safety_blocks.sv
`timescale 1ns/100ps
`default_nettype none
`include "safety_blocks_defines.svh"

module safety_blocks
    import safety_blocks_pkg::*;
#(
    parameter int SCAN_CYCLES = `SCAN_CYCLES
)(
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    input  wire logic                  enabling_switch_input,
    input  wire logic                  non_bypassable_stop_input,
    input  wire logic                  ed_block_reset_input,
    input  wire logic                  manual_reset_input,
    input  wire logic                  reset_permit_input,
    input  wire logic                  pair_one_sensor_a,
    input  wire logic                  pair_one_sensor_b,
    input  wire logic                  pair_two_sensor_a,
    input  wire logic                  pair_two_sensor_b,
    input  wire logic                  mute_permit_input,
    input  wire logic                  bypass_option,
    input  wire logic                  optical_safeguard_input,
    input  wire logic                  emergency_stop_input,
    input  wire safety_cfg_t           cfg,
    output logic                       first_safety_output,
    output logic                       second_safety_output,
    output logic                       second_output_ref,
    output logic                       enable_mode_active,
    output logic                       enable_expired,
    output logic                       mute_active
);

    localparam int SCW = $clog2(SCAN_CYCLES + 1);

    // ----------------------------------------
    // Scan enable and input synchronisers
    // ----------------------------------------
    logic [SCW-1:0]        scan_cnt_ff;
    logic                  scan_ff;
    logic [`PIN_COUNT-1:0] meta_ff;
    logic [`PIN_COUNT-1:0] pin_ff;
    logic [`PIN_COUNT-1:0] pins;

    assign pins = {emergency_stop_input, optical_safeguard_input, bypass_option,
                   mute_permit_input, pair_two_sensor_b, pair_two_sensor_a,
                   pair_one_sensor_b, pair_one_sensor_a, reset_permit_input,
                   manual_reset_input, ed_block_reset_input,
                   non_bypassable_stop_input, enabling_switch_input};

    // Scan pulse, one cycle per scan period
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            scan_cnt_ff <= '0;
            scan_ff     <= 1'b0;
        end
        else if (scan_cnt_ff == SCW'(SCAN_CYCLES - 1))
        begin
            scan_cnt_ff <= '0;
            scan_ff     <= 1'b1;
        end
        else
        begin
            scan_cnt_ff <= scan_cnt_ff + SCW'(1);
            scan_ff     <= 1'b0;
        end
    end

    // Two-stage synchroniser for every pin
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_ff <= '0;
            pin_ff  <= '0;
        end
        else
        begin
            meta_ff <= pins;
            pin_ff  <= meta_ff;
        end
    end

    logic enable_sw, stop_ok, ed_rst, man_rst, permit_pin;
    logic p1a, p1b, p2a, p2b, mute_permit, bypass_sw, guard, estop;
    assign enable_sw   = pin_ff[`PIN_ENABLE_SW];
    assign stop_ok     = pin_ff[`PIN_STOP];
    assign ed_rst      = pin_ff[`PIN_ED_RESET];
    assign man_rst     = pin_ff[`PIN_MAN_RESET];
    assign permit_pin  = pin_ff[`PIN_PERMIT];
    assign p1a         = pin_ff[`PIN_P1A];
    assign p1b         = pin_ff[`PIN_P1B];
    assign p2a         = pin_ff[`PIN_P2A];
    assign p2b         = pin_ff[`PIN_P2B];
    assign mute_permit = pin_ff[`PIN_MUTE_PERMIT];
    assign bypass_sw   = pin_ff[`PIN_BYPASS];
    assign guard       = pin_ff[`PIN_GUARD];
    assign estop       = pin_ff[`PIN_ESTOP];

    // ----------------------------------------
    // Enabling-device block
    // ----------------------------------------
    ed_state_t   ed_state_ff;
    ed_state_t   nxt_ed_state;
    logic [20:0] ed_timer_ff;
    logic [20:0] ed_limit;
    logic        enable_sw_prev_ff;
    logic        enable_rise;
    logic        ed_out;

    // Clamp the time limit into its legal range; zero never disables it
    assign ed_limit = (cfg.ed_limit_ms < `ED_LIMIT_MIN_MS) ? `ED_LIMIT_MIN_MS :
                      (cfg.ed_limit_ms > `ED_LIMIT_MAX_MS) ? `ED_LIMIT_MAX_MS :
                      cfg.ed_limit_ms;
    assign enable_rise = enable_sw & ~enable_sw_prev_ff;

    // Mode transitions of the enabling-device block
    always_comb
    begin
        nxt_ed_state = ed_state_ff;
        unique case (ed_state_ff)
            ED_RUN:
                if (enable_rise)
                    nxt_ed_state = ED_ENABLE;
            ED_ENABLE:
                if (ed_rst && !enable_sw)
                    nxt_ed_state = ED_RUN;
                else if (ed_timer_ff >= ed_limit)
                    nxt_ed_state = ED_EXPIRED;
            ED_EXPIRED:
                if (ed_rst && !enable_sw)
                    nxt_ed_state = ED_RUN;
                else if (enable_rise)
                    nxt_ed_state = ED_ENABLE;
            default:
                nxt_ed_state = ED_RUN;
        endcase
    end

    // Output authority per mode; the stop input gates every mode
    always_comb
    begin
        unique case (ed_state_ff)
            ED_RUN:     ed_out = guard & stop_ok;
            ED_ENABLE:  ed_out = enable_sw & stop_ok;
            default:    ed_out = 1'b0;
        endcase
    end

    // Enabling-device state and timer
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ed_state_ff       <= ED_RUN;
            ed_timer_ff       <= '0;
            enable_sw_prev_ff <= 1'b0;
        end
        else if (scan_ff)
        begin
            enable_sw_prev_ff <= enable_sw;
            ed_state_ff       <= nxt_ed_state;
            if (nxt_ed_state == ED_ENABLE && ed_state_ff != ED_ENABLE)
                ed_timer_ff <= '0;
            else if (ed_state_ff == ED_ENABLE)
                ed_timer_ff <= ed_timer_ff + 21'(`MS_PER_SCAN);
        end
    end

    // ----------------------------------------
    // Output delay stage of the second output
    // ----------------------------------------
    logic        second_out_ff;
    logic [15:0] dly_cnt_ff;
    logic [15:0] dly_target;

    assign dly_target = ed_out ? cfg.on_delay_ms : cfg.off_delay_ms;

    // On/off delays apply in every mode, enable mode included
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            second_out_ff <= 1'b0;
            dly_cnt_ff    <= '0;
        end
        else if (scan_ff)
        begin
            if (ed_out == second_out_ff)
                dly_cnt_ff <= '0;
            else if (dly_cnt_ff >= dly_target)
            begin
                second_out_ff <= ed_out;
                dly_cnt_ff    <= '0;
            end
            else
                dly_cnt_ff <= dly_cnt_ff + 16'(`MS_PER_SCAN);
        end
    end

    // ----------------------------------------
    // Muting block
    // ----------------------------------------
    mute_state_t mu_state_ff;
    mute_state_t nxt_mu_state;
    logic [11:0] mu_timer_ff;
    logic        two_pair, two_way;
    logic        lead_any, lead_both, any_sensor, all_clear;
    logic        protected_in, mute_out;

    assign two_pair   = (cfg.mute_type == MT_ONE_WAY_2P) || (cfg.mute_type == MT_TWO_WAY_2P);
    assign two_way    = (cfg.mute_type != MT_ONE_WAY_1P) && (cfg.mute_type != MT_ONE_WAY_2P);
    assign any_sensor = p1a | p1b | ((two_pair | (cfg.mute_type == MT_TWO_WAY_1P_X)) & (p2a | p2b));
    // One-way starts at pair one only; two-way may start from either pair
    assign lead_any   = (p1a | p1b) |
                        (two_way & (two_pair | (cfg.mute_type == MT_TWO_WAY_1P_X)) & (p2a | p2b));
    assign lead_both  = (p1a & p1b) |
                        (two_way & (two_pair | (cfg.mute_type == MT_TWO_WAY_1P_X)) & p2a & p2b);
    // Mute ends when every sensor in use has cleared
    assign all_clear  = ~any_sensor;
    // Emergency stop may be ANDed ahead of the mute and is then muted with it
    assign protected_in = guard & (cfg.estop_before_mute ? estop : 1'b1);

    // Mute sequencing
    always_comb
    begin
        nxt_mu_state = mu_state_ff;
        unique case (mu_state_ff)
            MU_IDLE:
                if (lead_any && mute_permit)
                    nxt_mu_state = MU_WAIT2;
            MU_WAIT2:
                if (!lead_any)
                    nxt_mu_state = MU_IDLE;
                else if (lead_both)
                    nxt_mu_state = MU_SETTLE;
                else if (mu_timer_ff >= `MUTE_SIMUL_MS)
                    nxt_mu_state = MU_BLOCK;
            MU_SETTLE:
                if (!lead_both)
                    nxt_mu_state = MU_WAIT2;
                else if (mu_timer_ff >= `MUTE_SETTLE_MS)
                    nxt_mu_state = MU_MUTED;
            MU_MUTED:
                if (all_clear)
                    nxt_mu_state = MU_IDLE;
            MU_BLOCK:
                if (all_clear)
                    nxt_mu_state = MU_IDLE;
            default:
                nxt_mu_state = MU_IDLE;
        endcase
        // Override restarts an incomplete cycle with a sensor on and guard stopped
        if (cfg.bypass_en && cfg.bypass_override && bypass_sw && any_sensor && !guard &&
            mu_state_ff != MU_MUTED)
            nxt_mu_state = MU_MUTED;
    end

    // Mute state and shared simultaneity/settle timer
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            mu_state_ff <= MU_IDLE;
            mu_timer_ff <= '0;
        end
        else if (scan_ff)
        begin
            mu_state_ff <= nxt_mu_state;
            if (nxt_mu_state != mu_state_ff)
                mu_timer_ff <= '0;
            else if (mu_timer_ff != 12'hFFF)
                mu_timer_ff <= mu_timer_ff + 12'(`MS_PER_SCAN);
        end
    end

    // Muting output: muted, bypassed, or following the protected input
    assign mute_out = (mu_state_ff == MU_MUTED) |
                      (cfg.bypass_en & ~cfg.bypass_override & bypass_sw) |
                      protected_in;

    // ----------------------------------------
    // Latch-reset block behind the mute
    // ----------------------------------------
    logic first_out_ff;
    logic man_prev_ff;
    logic man_armed_ff;
    logic trip_ff;
    logic muted_prev_ff;
    logic lr_run, lr_permit, reset_evt, muted_now;

    assign muted_now = (mu_state_ff == MU_MUTED);
    assign lr_run    = mute_out & (cfg.estop_before_mute ? 1'b1 : estop);
    // Permit comes from the pin or from the second output itself (second_out_ff), not from its reference flop
    assign lr_permit = cfg.permit_from_ref ? second_out_ff : permit_pin;
    // Monitored acts on release after a press, non-monitored on the press
    assign reset_evt = cfg.reset_monitored ? (man_prev_ff & ~man_rst & man_armed_ff)
                                           : (man_rst & ~man_prev_ff);

    // Reset button edge tracking
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            man_prev_ff  <= 1'b0;
            man_armed_ff <= 1'b0;
        end
        else if (scan_ff)
        begin
            man_prev_ff  <= man_rst;
            man_armed_ff <= man_rst ? 1'b1 : 1'b0;
        end
    end

    // Latch output, trip memory of a guard stop inside a mute
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            first_out_ff  <= 1'b0;
            trip_ff       <= 1'b0;
            muted_prev_ff <= 1'b0;
        end
        else if (scan_ff)
        begin
            muted_prev_ff <= muted_now;
            if (!lr_run)
                first_out_ff <= 1'b0;
            else if (muted_prev_ff && !muted_now && trip_ff)
                first_out_ff <= 1'b0;
            else if (reset_evt && lr_permit)
                first_out_ff <= 1'b1;
            // Guard stop during a mute sets the trip; set wins over a reset
            if (muted_now && !protected_in)
                trip_ff <= 1'b1;
            else if (reset_evt && lr_permit && lr_run)
                trip_ff <= 1'b0;
            else if (!muted_now)
                trip_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Status flops and outputs
    // ----------------------------------------
    logic ref_ff, enable_ff, expired_ff, mute_ff;

    // Status mirrors, one flop each
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ref_ff     <= 1'b0;
            enable_ff  <= 1'b0;
            expired_ff <= 1'b0;
            mute_ff    <= 1'b0;
        end
        else
        begin
            ref_ff     <= second_out_ff;
            enable_ff  <= (ed_state_ff == ED_ENABLE);
            expired_ff <= (ed_state_ff == ED_EXPIRED);
            mute_ff    <= muted_now;
        end
    end

    assign first_safety_output  = first_out_ff;
    assign second_safety_output = second_out_ff;
    assign second_output_ref    = ref_ff;
    assign enable_mode_active   = enable_ff;
    assign enable_expired       = expired_ff;
    assign mute_active          = mute_ff;

endmodule // safety_blocks

`default_nettype wire

// File: testbench/safety_blocks_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module safety_blocks_asserts
    import safety_blocks_pkg::*;
#(
    parameter int SCAN_CYCLES = 4
)(
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        enabling_switch_input,
    input  wire logic        non_bypassable_stop_input,
    input  wire logic        ed_block_reset_input,
    input  wire logic        pair_one_sensor_a,
    input  wire logic        pair_one_sensor_b,
    input  wire logic        emergency_stop_input,
    input  wire safety_cfg_t cfg,
    input  wire logic        first_safety_output,
    input  wire logic        second_safety_output,
    input  wire logic        enable_mode_active,
    input  wire logic        enable_expired,
    input  wire logic        mute_active
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    int en_cnt_ff;
    int both_cnt_ff;

    // Clocks spent in a live enable cycle
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn || !enable_mode_active || enable_expired)
            en_cnt_ff <= 0;
        else
            en_cnt_ff <= en_cnt_ff + 1;
    end

    // Clocks with both lead sensors active
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn || !(pair_one_sensor_a && pair_one_sensor_b))
            both_cnt_ff <= 0;
        else
            both_cnt_ff <= both_cnt_ff + 1;
    end

    // ----------------------------------------
    // Multi-step sequences
    // ----------------------------------------
    sequence stop_low_s;
        (!non_bypassable_stop_input && cfg.off_delay_ms == 16'h0000)[*8] ##1 (!non_bypassable_stop_input)[*3];
    endsequence

    sequence expired_s;
        (enable_expired && cfg.off_delay_ms == 16'h0000)[*8] ##1 enable_expired[*4];
    endsequence

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    reset_clear_a: assert property ($rose(resetn) |-> !first_safety_output && !second_safety_output
        && !enable_mode_active && !mute_active) else $error("outputs not clear after reset");
    stop_kills_a: assert property (stop_low_s |-> !second_safety_output)
        else $error("stop input did not drop second output");
    estop_latch_a: assert property ((emergency_stop_input == 1'b0 && !cfg.estop_before_mute)[*8]
        |-> !first_safety_output) else $error("e-stop did not drop first output");
    latch_rise_a: assert property ($rose(first_safety_output)
        |-> $past(emergency_stop_input, 2) || $past(emergency_stop_input, 3)) else $error("latch set in stop");
    enable_entry_a: assert property ($rose(enable_mode_active)
        |-> $past(enabling_switch_input, 3) || $past(enabling_switch_input, 4)) else $error("enable without switch");
    enable_exit_a: assert property ($fell(enable_mode_active) && !enable_expired
        |-> ($past(ed_block_reset_input, 3) || $past(ed_block_reset_input, 4))
        && (!$past(enabling_switch_input, 3) || !$past(enabling_switch_input, 4))) else $error("bad enable exit");
    expired_off_a: assert property (expired_s |-> !second_safety_output)
        else $error("output on after enable expiry");
    expired_time_a: assert property ($rose(enable_expired) |-> en_cnt_ff >= (int'(cfg.ed_limit_ms) - 1) * SCAN_CYCLES
        && en_cnt_ff <= (int'(cfg.ed_limit_ms) + 1) * SCAN_CYCLES) else $error("enable limit time wrong");
    mute_settle_a: assert property ($rose(mute_active) && !cfg.bypass_en |-> both_cnt_ff >= 100 * SCAN_CYCLES
        && both_cnt_ff <= 102 * SCAN_CYCLES + 3) else $error("mute settle time wrong");
endmodule // safety_blocks_asserts

bind safety_blocks safety_blocks_asserts #(.SCAN_CYCLES(SCAN_CYCLES)) u_asserts (
    .clk_sys(clk_sys), .resetn(resetn), .enabling_switch_input(enabling_switch_input),
    .non_bypassable_stop_input(non_bypassable_stop_input), .ed_block_reset_input(ed_block_reset_input),
    .pair_one_sensor_a(pair_one_sensor_a), .pair_one_sensor_b(pair_one_sensor_b),
    .emergency_stop_input(emergency_stop_input), .cfg(cfg), .first_safety_output(first_safety_output),
    .second_safety_output(second_safety_output), .enable_mode_active(enable_mode_active),
    .enable_expired(enable_expired), .mute_active(mute_active));

`default_nettype wire

// File: testbench/mute_sensor_pair.sv
`timescale 1ns/100ps
`default_nettype none

module mute_sensor_pair
    import safety_blocks_pkg::*;
#(
    parameter int SCAN_CYCLES = 4
)(
    input  wire logic        clk_sys,
    input  wire logic        arm,
    input  wire logic [15:0] gap_scans,
    output logic             sensor_a,
    output logic             sensor_b
);
    int wait_ff = 0;

    // Lead sensor first, second one after the gap; both clear when disarmed
    always @(negedge clk_sys)
    begin
        if (!arm)
        begin
            sensor_a <= 1'b0;
            sensor_b <= 1'b0;
            wait_ff  <= 0;
        end
        else
        begin
            sensor_a <= 1'b1;
            if (wait_ff >= gap_scans * SCAN_CYCLES)
                sensor_b <= 1'b1;
            else
                wait_ff <= wait_ff + 1;
        end
    end
endmodule // mute_sensor_pair

`default_nettype wire

// File: testbench/tb_safety_blocks.sv
`timescale 1ns/100ps
`default_nettype none

module tb_safety_blocks
    import safety_blocks_pkg::*;
;
    localparam int SC = 4;
    logic clk_sys, resetn, sw, stop, ed_rst, man_rst, permit, arm, mute_ok, bypass, guard, estop;
    logic s_a, s_b, out1, out2, ref2, en_act, en_exp, muted, p2;
    logic [15:0] gap;
    safety_cfg_t cfg;
    int errors = 0;
    int checks = 0;
    int cycles = 0;

    mute_sensor_pair #(.SCAN_CYCLES(SC)) sensors (.clk_sys(clk_sys), .arm(arm), .gap_scans(gap),
        .sensor_a(s_a), .sensor_b(s_b));

    safety_blocks #(.SCAN_CYCLES(SC)) uut (
        .clk_sys(clk_sys), .resetn(resetn), .enabling_switch_input(sw), .non_bypassable_stop_input(stop),
        .ed_block_reset_input(ed_rst), .manual_reset_input(man_rst), .reset_permit_input(permit),
        .pair_one_sensor_a(s_a), .pair_one_sensor_b(s_b), .pair_two_sensor_a(p2), .pair_two_sensor_b(p2),
        .mute_permit_input(mute_ok), .bypass_option(bypass), .optical_safeguard_input(guard),
        .emergency_stop_input(estop), .cfg(cfg), .first_safety_output(out1), .second_safety_output(out2),
        .second_output_ref(ref2), .enable_mode_active(en_act), .enable_expired(en_exp), .mute_active(muted));

    // ----------------------------------------
    // Clock, timeout and helpers
    // ----------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Cut a hang short
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            finish_test();
        end
    end

    task automatic sc(input int n);
        repeat (n * SC) @(negedge clk_sys);
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic press();
        man_rst = 1'b1;
        sc(3);
        man_rst = 1'b0;
        sc(2);
    endtask

    task automatic finish_test();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {resetn, sw, ed_rst, man_rst, permit, arm, bypass, p2} = 8'h00;
        {stop, mute_ok, guard, estop} = 4'hF;
        gap = 16'h000A;
        cfg = '0;
        cfg.ed_limit_ms = 21'h0003E8;
        cfg.on_delay_ms = 16'h0005;
        repeat (5) @(negedge clk_sys);
        chk({out1, out2, en_act, en_exp, muted}, 32'h0);
        resetn = 1'b1;
        sc(12);
        chk(out2, 1);
        // Enabling device block
        sw = 1'b1;
        sc(3);
        chk(en_act, 1);
        guard = 1'b0;
        sc(3);
        chk(out2, 1);
        stop = 1'b0;
        sc(3);
        chk(out2, 0);
        stop = 1'b1;
        sc(3);
        chk(out2, 0);
        sc(6);
        chk(out2, 1);
        ed_rst = 1'b1;
        sc(3);
        ed_rst = 1'b0;
        chk(en_act, 1);
        sc(950);
        chk(en_exp, 0);
        sc(60);
        chk(en_exp, 1);
        chk(out2, 0);
        sw = 1'b0;
        sc(3);
        sw = 1'b1;
        sc(3);
        chk(en_exp, 0);
        sc(9);
        chk(out2, 1);
        sw = 1'b0;
        ed_rst = 1'b1;
        sc(3);
        ed_rst = 1'b0;
        sc(1);
        chk(en_act, 0);
        guard = 1'b1;
        sc(9);
        chk(out2, 1);
        // Latch reset block
        press();
        chk(out1, 0);
        chk(ref2, 1);
        cfg.permit_from_ref = 1'b1;
        press();
        chk(out1, 1);
        cfg.permit_from_ref = 1'b0;
        permit = 1'b1;
        estop = 1'b0;
        sc(3);
        chk(out1, 0);
        estop = 1'b1;
        sc(3);
        chk(out1, 0);
        cfg.reset_monitored = 1'b1;
        man_rst = 1'b1;
        sc(3);
        chk(out1, 0);
        man_rst = 1'b0;
        sc(3);
        chk(out1, 1);
        cfg.reset_monitored = 1'b0;
        // Every mute type through one sensor pair
        for (int t = 0; t < 5; t++)
        begin
            cfg.mute_type = mute_type_t'(t);
            arm = 1'b1;
            sc(60);
            chk(muted, 0);
            sc(60);
            chk(muted, 1);
            arm = 1'b0;
            sc(4);
            chk(muted, 0);
        end
        // One-way two-pair type must not start a mute from pair two; then a guard stop inside a mute
        cfg.mute_type = MT_ONE_WAY_2P;
        p2 = 1'b1;
        sc(120);
        chk(muted, 0);
        p2 = 1'b0;
        cfg.mute_type = MT_ONE_WAY_1P;
        arm = 1'b1;
        sc(120);
        guard = 1'b0;
        sc(3);
        chk(out1, 1);
        arm = 1'b0;
        sc(3);
        chk(out1, 0);
        guard = 1'b1;
        press();
        arm = 1'b1;
        sc(120);
        guard = 1'b0;
        sc(3);
        guard = 1'b1;
        sc(3);
        press();
        arm = 1'b0;
        sc(3);
        chk(out1, 1);
        // Sensor pair too far apart
        gap = 16'h0C1C;
        arm = 1'b1;
        sc(3250);
        chk(muted, 0);
        arm = 1'b0;
        gap = 16'h000A;
        sc(3);
        // Normal bypass, then mute-dependent override
        cfg.bypass_en = 1'b1;
        bypass = 1'b1;
        guard = 1'b0;
        sc(3);
        chk(out1, 1);
        bypass = 1'b0;
        sc(3);
        chk(out1, 0);
        cfg.bypass_override = 1'b1;
        arm = 1'b1;
        bypass = 1'b1;
        sc(3);
        chk(muted, 1);
        arm = 1'b0;
        bypass = 1'b0;
        sc(3);
        chk(muted, 0);
        finish_test();
    end
endmodule // tb_safety_blocks

`default_nettype wire
